//--- hdl/sfs_pkg.sv
// Shared constants and types for the serial flash command sequencer
package sfs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [19:0] TOP_ADDR = 20'hF_FFFF;
  localparam logic [20:0] NO_PROT = 21'h10_0000;
  // Opcodes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_BPROG = 8'h02;
  localparam logic [7:0] OP_WPROG = 8'hAD;
  localparam logic [7:0] OP_SERASE = 8'h20;
  localparam logic [7:0] OP_B32 = 8'h52;
  localparam logic [7:0] OP_B64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hC7;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OP_EBSY = 8'h70;
  localparam logic [7:0] OP_DBSY = 8'h80;
  // Status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_AAI = 6;
  // Erase region sizes minus one
  localparam logic [19:0] SECT_MASK = 20'h0_0FFF;
  localparam logic [19:0] B32_MASK = 20'h0_7FFF;
  localparam logic [19:0] B64_MASK = 20'h0_FFFF;
  // Pin vector positions
  localparam int PIN_CE = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  typedef enum logic [2:0] {MC_NONE, MC_READ, MC_PROG, MC_ERASE_SECT, MC_ERASE_B32, MC_ERASE_B64,
    MC_ERASE_ALL} sfs_memcmd_t;
  typedef struct packed {
    sfs_memcmd_t cmd;
    logic [19:0] addr;
    logic [7:0] data;
  } sfs_mem_req_t;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_RDATA, PH_WDATA, PH_STAT, PH_IGN} sfs_phase_t;
endpackage : sfs_pkg

//--- hdl/sfs_top.sv
// Serial flash command sequencer: SPI slave, command decode, self-timed program and erase
`timescale 1ns/1ps
module sfs_top #(
  parameter int BYTE_PROGRAM_TIME_US = 10,
  parameter int SECTOR_ERASE_TIME_US = 25000,
  parameter int BLOCK_ERASE_TIME_US = 25000,
  parameter int CHIP_ERASE_TIME_US = 50000
) (
  input wire logic CLK_IN, // 100 MHz clock
  input wire logic ARST_N_IN, // Async reset, active low
  input wire logic CE_N_IN, // Chip select pin, active low
  input wire logic SCK_IN, // Serial clock pin
  input wire logic SI_IN, // Serial data in pin
  input wire logic [20:0] PROT_BASE_IN, // First protected address, 100000h none
  input wire logic [7:0] MEM_RDATA_IN, // Array byte at MEM_REQ_OUT.addr
  output logic SO_OUT, // Serial data out
  output logic SO_OE_OUT, // Serial out drive enable
  output sfs_pkg::sfs_mem_req_t MEM_REQ_OUT, // Array request
  output logic BUSY_OUT, // Operation running
  output logic WEL_OUT, // Write enable latch
  output logic AAI_OUT // Word program mode
);
  localparam int BP_CYC = BYTE_PROGRAM_TIME_US * 1000 / sfs_pkg::CLK_PERIOD_NS;
  localparam int SE_CYC = SECTOR_ERASE_TIME_US * 1000 / sfs_pkg::CLK_PERIOD_NS;
  localparam int BE_CYC = BLOCK_ERASE_TIME_US * 1000 / sfs_pkg::CLK_PERIOD_NS;
  localparam int CE_CYC = CHIP_ERASE_TIME_US * 1000 / sfs_pkg::CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0] p1, p2, p3, filt;
    sfs_pkg::sfs_phase_t ph;
    logic [2:0] cnt;
    logic [1:0] bcnt, ndat;
    logic [7:0] sr, opc, d0, d1, oshr;
    logic [23:0] addr;
    logic [19:0] rptr, aptr, wr2_a;
    logic busy, write_enable_latch, auto_increment_program, ebsy, aai_end, wr2, so, so_oe;
    logic [31:0] tmr;
    logic [7:0] wr2_d;
    sfs_pkg::sfs_mem_req_t req;
  } sfs_state_t;

  sfs_state_t q, n;
  logic [1:0] rst_q;
  logic rst_n;
  logic ce_rise, sck_rise, sck_fall, ld, go, hit, write_disable_cmd_go;
  logic [7:0] byte_v, st;
  logic [19:0] ea, eend;
  sfs_pkg::sfs_memcmd_t ecmd;
  logic [31:0] etime;

  // Reset release through two stages
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Next-state logic for the whole sequencer
  always_comb begin
    n = q;
    ce_rise = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    ld = 1'b0;
    go = 1'b0;
    hit = 1'b0;
    write_disable_cmd_go = 1'b0;
    ea = '0;
    eend = '0;
    ecmd = sfs_pkg::MC_NONE;
    etime = '0;
    // Pin filter: a level counts once the last two stages agree
    n.p1 = {SI_IN, SCK_IN, CE_N_IN};
    n.p2 = q.p1;
    n.p3 = q.p2;
    for (int i = 0; i < 3; i++) begin
      if (q.p2[i] == q.p3[i]) begin
        n.filt[i] = q.p3[i];
      end
    end
    ce_rise = n.filt[sfs_pkg::PIN_CE] & ~q.filt[sfs_pkg::PIN_CE];
    sck_rise = ~q.filt[sfs_pkg::PIN_CE] & n.filt[sfs_pkg::PIN_SCK] & ~q.filt[sfs_pkg::PIN_SCK];
    sck_fall = ~q.filt[sfs_pkg::PIN_CE] & ~n.filt[sfs_pkg::PIN_SCK] & q.filt[sfs_pkg::PIN_SCK];
    byte_v = {q.sr[6:0], n.filt[sfs_pkg::PIN_SI]};
    st = '0;
    st[sfs_pkg::ST_BUSY] = q.busy;
    st[sfs_pkg::ST_WEL] = q.write_enable_latch;
    st[sfs_pkg::ST_AAI] = q.auto_increment_program;
    // Array port: read address follows the pointer, second word byte goes next
    n.req.cmd = (q.ph == sfs_pkg::PH_RDATA) ? sfs_pkg::MC_READ : sfs_pkg::MC_NONE;
    n.req.addr = q.rptr;
    n.req.data = 8'h00;
    n.wr2 = 1'b0;
    if (q.wr2) begin
      n.req = '{sfs_pkg::MC_PROG, q.wr2_a, q.wr2_d};
    end
    if (q.busy) begin
      if (q.tmr == 32'h0000_0000) begin
        n.busy = 1'b0;
        if (q.aai_end) begin
          n.auto_increment_program = 1'b0;
          n.write_enable_latch = 1'b0;
          n.aai_end = 1'b0;
        end
      end else begin
        n.tmr = q.tmr - 32'h0000_0001;
      end
    end
    // Deselected: bus idle, output released
    if (q.filt[sfs_pkg::PIN_CE]) begin
      n.ph = sfs_pkg::PH_CMD;
      n.cnt = '0;
      n.bcnt = '0;
      n.ndat = '0;
      n.opc = sfs_pkg::OP_NONE;
      n.so_oe = 1'b0;
    end
    if (!q.filt[sfs_pkg::PIN_CE] && q.ebsy && q.auto_increment_program && q.ph != sfs_pkg::PH_STAT) begin
      n.so_oe = 1'b1;
      n.so = ~q.busy;
    end
    // Serial input shifts on rising clock
    if (sck_rise) begin
      n.sr = byte_v;
      n.cnt = q.cnt + 3'd1;
      if (q.cnt == 3'd7) begin
        unique case (q.ph)
          sfs_pkg::PH_CMD: begin
            n.opc = byte_v;
            n.ph = sfs_pkg::PH_IGN;
            if (q.auto_increment_program) begin
              if (byte_v == sfs_pkg::OP_WPROG) begin
                n.ph = sfs_pkg::PH_WDATA;
              end else if (byte_v == sfs_pkg::OP_STATUS_READ_CMD) begin
                n.ph = sfs_pkg::PH_STAT;
              end else if (byte_v != sfs_pkg::OP_WRITE_DISABLE_CMD) begin
                n.opc = sfs_pkg::OP_NONE;
              end
            end else if (byte_v == sfs_pkg::OP_STATUS_READ_CMD) begin
              n.ph = sfs_pkg::PH_STAT;
            end else if (byte_v inside {sfs_pkg::OP_FREAD, sfs_pkg::OP_BPROG, sfs_pkg::OP_WPROG,
                sfs_pkg::OP_SERASE, sfs_pkg::OP_B32, sfs_pkg::OP_B64}) begin
              n.ph = (q.busy && byte_v == sfs_pkg::OP_FREAD) ? sfs_pkg::PH_IGN : sfs_pkg::PH_ADDR;
            end
          end
          sfs_pkg::PH_ADDR: begin
            n.addr = {q.addr[15:0], byte_v};
            n.bcnt = q.bcnt + 2'd1;
            if (q.bcnt == 2'd2) begin
              n.rptr = n.addr[19:0];
              n.ph = (q.opc == sfs_pkg::OP_FREAD) ? sfs_pkg::PH_DUMMY :
                (q.opc == sfs_pkg::OP_BPROG || q.opc == sfs_pkg::OP_WPROG) ? sfs_pkg::PH_WDATA :
                sfs_pkg::PH_IGN;
            end
          end
          sfs_pkg::PH_DUMMY: n.ph = sfs_pkg::PH_RDATA;
          sfs_pkg::PH_WDATA: begin
            if (q.ndat == 2'd0) begin
              n.d0 = byte_v;
            end
            if (q.ndat == 2'd1) begin
              n.d1 = byte_v;
            end
            if (q.ndat != 2'd3) begin
              n.ndat = q.ndat + 2'd1;
            end
          end
          sfs_pkg::PH_RDATA, sfs_pkg::PH_STAT, sfs_pkg::PH_IGN: n.cnt = 3'd0;
        endcase
      end
    end
    // Serial output changes on falling clock, new byte when count is zero
    if (sck_fall && (q.ph == sfs_pkg::PH_RDATA || q.ph == sfs_pkg::PH_STAT)) begin
      n.so_oe = 1'b1;
      if (q.cnt == 3'd0) begin
        ld = (q.ph == sfs_pkg::PH_RDATA);
        n.so = ld ? MEM_RDATA_IN[7] : st[7];
        n.oshr = ld ? {MEM_RDATA_IN[6:0], 1'b0} : {st[6:0], 1'b0};
        if (ld) begin
          n.rptr = q.rptr + 20'h0_0001;
        end
      end else begin
        n.so = q.oshr[7];
        n.oshr = {q.oshr[6:0], 1'b0};
      end
    end
    if (ce_rise && q.cnt == 3'd0) begin
      ea = q.addr[19:0];
      unique case (q.opc)
        sfs_pkg::OP_WRITE_ENABLE_CMD: n.write_enable_latch = q.busy ? q.write_enable_latch : 1'b1;
        sfs_pkg::OP_WRITE_DISABLE_CMD: write_disable_cmd_go = 1'b1;
        sfs_pkg::OP_EBSY: n.ebsy = 1'b1;
        sfs_pkg::OP_DBSY: n.ebsy = 1'b0;
        sfs_pkg::OP_BPROG: begin
          go = q.bcnt == 2'd3 && q.ndat == 2'd1;
          eend = ea;
          ecmd = sfs_pkg::MC_PROG;
          etime = 32'(BP_CYC - 1);
        end
        sfs_pkg::OP_WPROG: begin
          go = q.ndat == 2'd2 && (q.auto_increment_program || q.bcnt == 2'd3);
          ea = q.auto_increment_program ? q.aptr : {q.addr[19:1], 1'b0};
          eend = ea | 20'h0_0001;
          ecmd = sfs_pkg::MC_PROG;
          etime = 32'(BP_CYC - 1);
        end
        sfs_pkg::OP_SERASE: begin
          go = q.bcnt == 2'd3;
          ea = q.addr[19:0] & ~sfs_pkg::SECT_MASK;
          eend = ea | sfs_pkg::SECT_MASK;
          ecmd = sfs_pkg::MC_ERASE_SECT;
          etime = 32'(SE_CYC - 1);
        end
        sfs_pkg::OP_B32: begin
          go = q.bcnt == 2'd3;
          ea = q.addr[19:0] & ~sfs_pkg::B32_MASK;
          eend = ea | sfs_pkg::B32_MASK;
          ecmd = sfs_pkg::MC_ERASE_B32;
          etime = 32'(BE_CYC - 1);
        end
        sfs_pkg::OP_B64: begin
          go = q.bcnt == 2'd3;
          ea = q.addr[19:0] & ~sfs_pkg::B64_MASK;
          eend = ea | sfs_pkg::B64_MASK;
          ecmd = sfs_pkg::MC_ERASE_B64;
          etime = 32'(BE_CYC - 1);
        end
        sfs_pkg::OP_CE1, sfs_pkg::OP_CE2: begin
          go = 1'b1;
          ea = '0;
          eend = sfs_pkg::TOP_ADDR;
          ecmd = sfs_pkg::MC_ERASE_ALL;
          etime = 32'(CE_CYC - 1);
        end
        default: go = 1'b0;
      endcase
      hit = {1'b0, eend} >= PROT_BASE_IN;
      go = go && q.write_enable_latch && !q.busy && !hit;
      if (write_disable_cmd_go) begin
        n.write_enable_latch = 1'b0;
        n.auto_increment_program = 1'b0;
        n.aai_end = 1'b0;
      end
      if (go) begin
        n.busy = 1'b1;
        n.tmr = etime;
        n.req = '{ecmd, ea, q.d0};
        if (q.opc == sfs_pkg::OP_WPROG) begin
          n.auto_increment_program = 1'b1;
          n.wr2 = 1'b1;
          n.wr2_a = eend;
          n.wr2_d = q.d1;
          n.aptr = ea + 20'h0_0002;
          // stop before protected area or top
          n.aai_end = ({1'b0, ea} + 21'h00_0002) >= PROT_BASE_IN;
        end else begin
          n.write_enable_latch = 1'b0;
        end
      end
    end
  end

  // Single state register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      // Pin stages start at idle levels, so no false select rise follows reset
      q.p1 <= 3'h1 << sfs_pkg::PIN_CE;
      q.p2 <= 3'h1 << sfs_pkg::PIN_CE;
      q.p3 <= 3'h1 << sfs_pkg::PIN_CE;
      q.filt <= 3'h1 << sfs_pkg::PIN_CE;
    end else begin
      q <= n;
    end
  end

  assign SO_OUT = q.so;
  assign SO_OE_OUT = q.so_oe;
  assign MEM_REQ_OUT = q.req;
  assign BUSY_OUT = q.busy;
  assign WEL_OUT = q.write_enable_latch;
  assign AAI_OUT = q.auto_increment_program;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  a_read_wrap: assert property (ld && q.rptr == sfs_pkg::TOP_ADDR |=> q.rptr == 20'h0_0000)
    else $error("read pointer did not wrap");
  a_read_step: assert property (ld |=> q.rptr == $past(q.rptr) + 20'h0_0001)
    else $error("read pointer did not advance");
  a_go_needs_wel: assert property (ce_rise && q.cnt == 3'd0 && !q.write_enable_latch && !q.busy |=> !q.busy)
    else $error("operation started without write enable");
  a_prot_block: assert property (ce_rise && hit |=> !q.busy || $past(q.busy))
    else $error("protected target started an operation");
  a_busy_start: assert property (go |=> q.busy ##1 q.busy)
    else $error("busy not raised at start");
  a_abort_mid: assert property (ce_rise && q.cnt != 3'd0 && !q.busy |=> !q.busy && q.write_enable_latch == $past(q.write_enable_latch))
    else $error("partial byte executed a command");
  a_write_disable_cmd_clear: assert property (write_disable_cmd_go |=> !q.write_enable_latch && !q.auto_increment_program)
    else $error("write disable left latches set");
  a_sector_align: assert property (q.req.cmd == sfs_pkg::MC_ERASE_SECT |-> q.req.addr[11:0] == 12'h000)
    else $error("sector erase address not aligned");
  a_rybsy_drive: assert property (!q.filt[sfs_pkg::PIN_CE] && q.ebsy && q.auto_increment_program && q.ph == sfs_pkg::PH_WDATA
    |=> q.so_oe && q.so == !$past(q.busy))
    else $error("ready busy output wrong");
  a_word_pair: assert property (go && q.opc == sfs_pkg::OP_WPROG |=> q.wr2 ##1 q.req.addr[0])
    else $error("second word byte not at odd address");

  c_fast_read: cover property (ld ##[1:200] ld);
  c_word_prog: cover property (go && q.auto_increment_program);
  c_chip_erase: cover property (go && ecmd == sfs_pkg::MC_ERASE_ALL);
  c_abort: cover property (ce_rise && q.cnt != 3'd0);
endmodule : sfs_top

//--- sim/sfs_host_model.sv
// SPI host model: drives chip select, serial clock and serial data
`timescale 1ns/1ps
module sfs_host_model (
  output logic ce_n_out, // Chip select, active low
  output logic sck_out, // Serial clock, low between frames
  output logic si_out, // Serial data to device
  input wire logic so_in // Serial data from device
);
  logic [7:0] rx_q[$];

  // Idle pins before the first frame
  initial begin
    ce_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end

  // One frame of 125 ns bits; cut drops trailing bits to abort mid-byte
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int cut);
    int nb;
    logic [7:0] sh;
    logic [7:0] rx_sh;
    nb = (tx.size() + nrx) * 8 - cut;
    rx_q.delete();
    ce_n_out = 1'b0;
    #62.5;
    for (int i = 0; i < nb; i++) begin
      sh = (i / 8 < tx.size()) ? tx[i / 8] : 8'h00;
      si_out = sh[7 - i % 8];
      #62.5 sck_out = 1'b1;
      rx_sh = {rx_sh[6:0], so_in};
      if (i % 8 == 7) rx_q.push_back(rx_sh);
      #62.5 sck_out = 1'b0;
    end
    // Released data line must not look like a held bit
    si_out = ~si_out;
    #62.5 ce_n_out = 1'b1;
    #250;
  endtask : xfer
endmodule : sfs_host_model

//--- sim/sfs_tb_top.sv
// Testbench for the serial flash command sequencer
`timescale 1ns/1ps
module sfs_tb_top;
  logic clk;
  logic arst_n;
  logic [20:0] prot;
  logic [7:0] rdata;
  logic ce_n, sck, si, so, so_oe, busy, write_enable_latch, auto_increment_program;
  logic so_pin;
  sfs_pkg::sfs_mem_req_t req;
  logic [7:0] mem[int];
  int n_errors = 0;
  int n_checks = 0;

  sfs_top #(.BYTE_PROGRAM_TIME_US(20), .SECTOR_ERASE_TIME_US(1), .BLOCK_ERASE_TIME_US(1),
    .CHIP_ERASE_TIME_US(1)) u_sfs_top (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_N_IN(ce_n),
    .SCK_IN(sck), .SI_IN(si), .PROT_BASE_IN(prot), .MEM_RDATA_IN(rdata), .SO_OUT(so),
    .SO_OE_OUT(so_oe), .MEM_REQ_OUT(req), .BUSY_OUT(busy), .WEL_OUT(write_enable_latch), .AAI_OUT(auto_increment_program));
  // Undriven serial out shows the inverse of its last level, so a late drive is caught
  assign so_pin = so_oe ? so : ~so;
  sfs_host_model u_sfs_host_model (.ce_n_out(ce_n), .sck_out(sck), .si_out(si), .so_in(so_pin));

  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd

  // Array model: erased cells read FF, program can only clear bits
  always @(posedge clk) begin
    rdata <= rd(int'(req.addr));
    case (req.cmd)
      sfs_pkg::MC_PROG: mem[int'(req.addr)] = rd(int'(req.addr)) & req.data;
      sfs_pkg::MC_ERASE_SECT: for (int i = 0; i < 'h1000; i++) mem.delete(int'(req.addr) + i);
      sfs_pkg::MC_ERASE_B32: for (int i = 0; i < 'h8000; i++) mem.delete(int'(req.addr) + i);
      sfs_pkg::MC_ERASE_B64: for (int i = 0; i < 'h10000; i++) mem.delete(int'(req.addr) + i);
      sfs_pkg::MC_ERASE_ALL: mem.delete();
      default: ;
    endcase
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] tx[$], input int nrx = 0, input int cut = 0);
    // Frames start just after a clock edge, so later checks never race an edge
    @(posedge clk);
    #1;
    u_sfs_host_model.xfer(tx, nrx, cut);
  endtask : xfer

  task automatic write_enable_cmd();
    xfer('{8'h06});
  endtask : write_enable_cmd

  task automatic setp(logic [20:0] v);
    @(posedge clk);
    #1 prot = v;
  endtask : setp

  task automatic idle();
    chk("busy_start", busy, 1'b1);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      n_errors++;
      $display("mismatch busy_end expected 0 seen %b", busy);
      summarize();
    end
  endtask : idle

  // Select without a command and look at the serial output
  task automatic rb(logic v, logic oe);
    @(posedge clk);
    #1 u_sfs_host_model.ce_n_out = 1'b0;
    #120;
    chk("rb_oe", so_oe, oe);
    if (oe) chk("rb_so", so, v);
    u_sfs_host_model.ce_n_out = 1'b1;
    #120;
    chk("rb_off", so_oe, 1'b0);
  endtask : rb

  task automatic t_read();
    mem['hFFFFE] = 8'h3C;
    mem['hFFFFF] = 8'hA5;
    mem[0] = 8'h5A;
    xfer('{8'h0B, 8'h0F, 8'hFF, 8'hFE, 8'h00}, 3);
    chk("rd0", u_sfs_host_model.rx_q[5], 8'h3C);
    chk("rd1", u_sfs_host_model.rx_q[6], 8'hA5);
    chk("rd2", u_sfs_host_model.rx_q[7], 8'h5A);
    $display("done read");
  endtask : t_read

  task automatic t_abort();
    xfer('{8'h06}, 0, 1);
    chk("write_enable_cmd_cut", write_enable_latch, 1'b0);
    write_enable_cmd();
    xfer('{8'h02, 8'h00, 8'h20, 8'h00, 8'h00}, 0, 1);
    chk("prog_cut", busy, 1'b0);
    xfer('{8'h04});
    $display("done abort");
  endtask : t_abort

  task automatic t_prog();
    xfer('{8'h02, 8'h00, 8'h10, 8'h00, 8'h81});
    chk("no_wel", busy, 1'b0);
    write_enable_cmd();
    chk("wel_set", write_enable_latch, 1'b1);
    xfer('{8'h02, 8'h00, 8'h10, 8'h00, 8'h81});
    chk("wel_clr", write_enable_latch, 1'b0);
    xfer('{8'h05}, 2);
    chk("st_busy", u_sfs_host_model.rx_q[2], 8'h01);
    idle();
    chk("prog", rd('h1000), 8'h81);
    setp(21'h08_0000);
    write_enable_cmd();
    xfer('{8'h02, 8'h08, 8'h00, 8'h00, 8'h00});
    chk("prot_prog", busy, 1'b0);
    xfer('{8'h60});
    chk("prot_chip", busy, 1'b0);
    xfer('{8'h04});
    setp(sfs_pkg::NO_PROT);
    $display("done program");
  endtask : t_prog

  task automatic t_erase();
    logic [7:0] op[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
    int m[5] = '{'h0FFF, 'h7FFF, 'hFFFF, 'hFFFFF, 'hFFFFF};
    int b;
    for (int k = 0; k < 5; k++) begin
      b = 'h3DA5C & ~m[k];
      mem[b] = 8'h00;
      mem[b + m[k]] = 8'h00;
      mem[b - 1] = 8'h00;
      mem[b + m[k] + 1] = 8'h00;
      write_enable_cmd();
      if (k < 3) xfer('{op[k], 8'h03, 8'hDA, 8'h5C});
      else xfer('{op[k]});
      idle();
      chk("erase_lo", rd(b), 8'hFF);
      chk("erase_hi", rd(b + m[k]), 8'hFF);
      if (k < 3) chk("keep_below", rd(b - 1), 8'h00);
      if (k < 3) chk("keep_above", rd(b + m[k] + 1), 8'h00);
    end
    $display("done erase");
  endtask : t_erase

  task automatic t_word();
    setp(21'h0_1238);
    xfer('{8'h70});
    write_enable_cmd();
    xfer('{8'hAD, 8'h00, 8'h12, 8'h35, 8'h11, 8'h22});
    chk("aai_on", auto_increment_program, 1'b1);
    rb(1'b0, 1'b1);
    idle();
    rb(1'b1, 1'b1);
    xfer('{8'h02, 8'h00, 8'h30, 8'h00, 8'h00});
    chk("bad_op", busy, 1'b0);
    xfer('{8'hAD, 8'h33, 8'h44});
    idle();
    chk("aai_end", auto_increment_program, 1'b0);
    chk("wel_end", write_enable_latch, 1'b0);
    chk("w0", rd('h1234), 8'h11);
    chk("w1", rd('h1235), 8'h22);
    chk("w2", rd('h1236), 8'h33);
    chk("w3", rd('h1237), 8'h44);
    setp(sfs_pkg::NO_PROT);
    xfer('{8'h80});
    write_enable_cmd();
    xfer('{8'hAD, 8'h00, 8'h20, 8'h00, 8'h55, 8'h66});
    rb(1'b0, 1'b0);
    xfer('{8'h04});
    chk("write_disable_cmd_aai", auto_increment_program, 1'b0);
    chk("write_disable_cmd_wel", write_enable_latch, 1'b0);
    idle();
    chk("write_disable_cmd_done", rd('h2001), 8'h66);
    $display("done word");
  endtask : t_word

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    prot = sfs_pkg::NO_PROT;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_read();
    t_abort();
    t_prog();
    t_erase();
    t_word();
    summarize();
  end
endmodule : sfs_tb_top
